//--- logic/frg_pkg.sv
// frg_pkg: constants, register map and types for the frequency ramp generator
package frg_pkg;
  // widths
  localparam int NUM_W = 34;  // signed numerator, +-2^33-1
  localparam int INC_W = 30;
  localparam int LEN_W = 16;
  localparam int REP_W = 13;
  localparam int DEN_LOG2 = 24;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_SEG0_INC  = 8'h08;
  localparam logic [7:0] OFF_SEG1_INC  = 8'h0c;
  localparam logic [7:0] OFF_SEG0_LEN  = 8'h10;
  localparam logic [7:0] OFF_SEG1_LEN  = 8'h14;
  localparam logic [7:0] OFF_SEG_CFG   = 8'h18;
  localparam logic [7:0] OFF_REPEAT    = 8'h1c;
  localparam logic [7:0] OFF_START     = 8'h20;
  localparam logic [7:0] OFF_LIM_LO_L  = 8'h24;
  localparam logic [7:0] OFF_LIM_LO_H  = 8'h28;
  localparam logic [7:0] OFF_LIM_HI_L  = 8'h2c;
  localparam logic [7:0] OFF_LIM_HI_H  = 8'h30;
  localparam logic [7:0] OFF_NUM_L     = 8'h34;
  localparam logic [7:0] OFF_NUM_H     = 8'h38;
  localparam logic [7:0] OFF_DEN       = 8'h3c;
  // control bits
  localparam int CTRL_EN    = 0;
  localparam int CTRL_PIN   = 1;
  localparam int CTRL_HALF  = 2;
  localparam int CTRL_RECAL = 3;
  localparam int CTRL_START = 4;
  // segment configuration fields
  localparam int CFG_NEXT0  = 0;
  localparam int CFG_NEXT1  = 1;
  localparam int CFG_ADV0   = 2;
  localparam int CFG_ADV1   = 4;
  localparam int CFG_RST0   = 6;
  localparam int CFG_RST1   = 7;
  localparam int CFG_TRIGA  = 8;
  localparam int CFG_TRIGB  = 12;
  localparam int CFG_REPSRC = 16;
  // reset values
  localparam logic [31:0] RST_CFG    = 32'h0000_0000;
  localparam logic [31:0] RST_DEN    = 32'hffff_ffff;
  localparam logic [NUM_W-1:0] RST_LIM_LO = 34'h2_0000_0001;
  localparam logic [NUM_W-1:0] RST_LIM_HI = 34'h1_ffff_ffff;
  // event source encodings
  localparam logic [1:0] SRC_TIMEOUT = 2'h0;
  localparam logic [1:0] SRC_TRIG_A  = 2'h1;
  localparam logic [1:0] SRC_TRIG_B  = 2'h2;
  localparam logic [3:0] TRG_OFF      = 4'h0;
  localparam logic [3:0] TRG_CLK_RISE = 4'h1;
  localparam logic [3:0] TRG_DIR_RISE = 4'h2;
  localparam logic [3:0] TRG_ALWAYS   = 4'h4;
  localparam logic [3:0] TRG_CLK_FALL = 4'h9;
  localparam logic [3:0] TRG_DIR_FALL = 4'ha;
  // automatic ramp states
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} frg_state_type;
endpackage

//--- logic/frg_pin_sync.sv
// frg_pin_sync: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module frg_pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // pin and clean level
  input  wire logic pinIn,
  output logic      level
);
  logic s1_reg, s2_reg, s3_reg, level_reg;
  logic levelNext;

  // level only moves once stages two and three agree; stage one feeds stage two only
  always_comb begin
    levelNext = level_reg;
    if (s2_reg == s3_reg) begin
      levelNext = s3_reg;
    end
  end

  // shift chain
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      s1_reg    <= pinIn;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= levelNext;
    end
  end

  assign level = level_reg;
endmodule

//--- logic/frg_ramp_top.sv
// frg_ramp_top: ramp generator core with Avalon-MM register slave
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ps
module frg_ramp_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // avalon-mm slave
  input  wire logic [7:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWritedata,
  output logic [31:0]      avsReaddata,
  output logic             avsWaitrequest,
  // step pins from external controller
  input  wire logic        stepClockPin,
  input  wire logic        stepDirectionPin,
  // vco calibration handshake
  input  wire logic        vcoCalBusy,
  output logic             vcoCalRequest,
  // synthesizer fraction outputs
  output logic [33:0]      fracNumerator,
  output logic [31:0]      fracDenominator,
  output logic             rampActive
);
  localparam int NW = frg_pkg::NUM_W;

  // configuration registers
  logic [4:0]       ctrl_reg, ctrl_next;          // start bit reads back 0
  logic [29:0]      inc0_reg, inc0_next, inc1_reg, inc1_next;
  logic [15:0]      len0_reg, len0_next, len1_reg, len1_next;
  logic [17:0]      cfg_reg, cfg_next;
  logic [12:0]      rep_reg, rep_next;
  logic [31:0]      start_reg, start_next;
  logic [NW-1:0]    limLo_reg, limLo_next, limHi_reg, limHi_next;
  logic [31:0]      den_reg, den_next;
  // bus state
  logic             ack_reg, ack_next;
  logic [31:0]      rdata_reg, rdata_next;
  // ramp state
  frg_pkg::frg_state_type state_reg, state_next;
  logic             seg_reg, seg_next;            // active segment
  logic [15:0]      cnt_reg, cnt_next;            // ramp cycles in segment
  logic [12:0]      repCnt_reg, repCnt_next;
  logic             half_reg, half_next;          // ramp clock divider phase
  logic [NW-1:0]    num_reg, num_next;
  logic [31:0]      origin_reg, origin_next;      // numerator at ramp start
  logic             cal_reg, cal_next;
  logic [31:0]      denOut_reg, denOut_next;
  logic             clkPrev_reg, dirPrev_reg;
  // synchronised pin levels
  logic             clkLvl, dirLvl;

  // pins cross into the pd clock domain before any edge is looked at
  frg_pin_sync u_clkSync (.clk(clk), .resetn(resetn), .pinIn(stepClockPin), .level(clkLvl));
  frg_pin_sync u_dirSync (.clk(clk), .resetn(resetn), .pinIn(stepDirectionPin), .level(dirLvl));

  // edge strobes on clean levels
  logic clkRise, clkFall, dirRise, dirFall;
  assign clkRise = clkLvl & ~clkPrev_reg;
  assign clkFall = ~clkLvl & clkPrev_reg;
  assign dirRise = dirLvl & ~dirPrev_reg;
  assign dirFall = ~dirLvl & dirPrev_reg;

  // trigger decode; undefined codes never fire
  function automatic logic trigHit(input logic [3:0] code, input logic cr, input logic cf,
                                   input logic dr, input logic df);
    case (code)
      frg_pkg::TRG_CLK_RISE: trigHit = cr;
      frg_pkg::TRG_DIR_RISE: trigHit = dr;
      frg_pkg::TRG_ALWAYS:   trigHit = 1'b1;
      frg_pkg::TRG_CLK_FALL: trigHit = cf;
      frg_pkg::TRG_DIR_FALL: trigHit = df;
      default:               trigHit = 1'b0;
    endcase
  endfunction

  // signed add with saturation at the programmed limits
  function automatic logic [NW-1:0] stepClamp(input logic [NW-1:0] cur, input logic [29:0] inc,
                                              input logic [NW-1:0] lo, input logic [NW-1:0] hi);
    logic signed [NW:0] sum;
    sum = $signed({cur[NW-1], cur}) + $signed({{(NW-29){inc[29]}}, inc});
    if (sum < $signed({lo[NW-1], lo})) begin
      stepClamp = lo;
    end else if (sum > $signed({hi[NW-1], hi})) begin
      stepClamp = hi;
    end else begin
      stepClamp = sum[NW-1:0];
    end
  endfunction

  // decoded controls
  logic en, pinMode, halve, recal, manualOn, autoOn, trigA, trigB, tick;
  logic busReq, wrNow, startPulse, advance, advTime, repEvent, curRst, curNext;
  logic [1:0]  curAdv, repSrc;
  logic [15:0] curLen;
  assign en       = ctrl_reg[frg_pkg::CTRL_EN];
  assign pinMode  = ctrl_reg[frg_pkg::CTRL_PIN];
  assign halve    = ctrl_reg[frg_pkg::CTRL_HALF];
  assign recal    = ctrl_reg[frg_pkg::CTRL_RECAL];
  assign manualOn = en & pinMode;
  assign autoOn   = en & ~pinMode;
  assign busReq   = avsRead | avsWrite;
  assign wrNow    = avsWrite & ack_reg;
  // judged on the written mode bits, so enable and start may share one write
  assign startPulse = wrNow & (avsAddress == frg_pkg::OFF_CTRL)
                      & avsWritedata[frg_pkg::CTRL_START] & avsWritedata[frg_pkg::CTRL_EN]
                      & ~avsWritedata[frg_pkg::CTRL_PIN];
  assign trigA    = trigHit(cfg_reg[frg_pkg::CFG_TRIGA +: 4], clkRise, clkFall, dirRise, dirFall);
  assign trigB    = trigHit(cfg_reg[frg_pkg::CFG_TRIGB +: 4], clkRise, clkFall, dirRise, dirFall);
  assign curAdv   = seg_reg ? cfg_reg[frg_pkg::CFG_ADV1 +: 2] : cfg_reg[frg_pkg::CFG_ADV0 +: 2];
  assign curRst   = seg_reg ? cfg_reg[frg_pkg::CFG_RST1] : cfg_reg[frg_pkg::CFG_RST0];
  assign curNext  = seg_reg ? cfg_reg[frg_pkg::CFG_NEXT1] : cfg_reg[frg_pkg::CFG_NEXT0];
  assign curLen   = seg_reg ? len1_reg : len0_reg;
  assign repSrc   = cfg_reg[frg_pkg::CFG_REPSRC +: 2];
  // ramp clock: every pd cycle or every other; calibration time is added on top
  assign tick     = (~halve | half_reg) & ~vcoCalBusy;
  assign advTime  = (curAdv == frg_pkg::SRC_TIMEOUT) & tick & (cnt_reg >= curLen);
  assign advance  = (state_reg == frg_pkg::ST_RUN) & (advTime
                    | ((curAdv == frg_pkg::SRC_TRIG_A) & trigA)
                    | ((curAdv == frg_pkg::SRC_TRIG_B) & trigB));
  // code 3 (reserved) matches nothing, so counter never moves for it
  assign repEvent = (state_reg == frg_pkg::ST_RUN) & (((repSrc == frg_pkg::SRC_TIMEOUT) & advance)
                    | ((repSrc == frg_pkg::SRC_TRIG_A) & trigA)
                    | ((repSrc == frg_pkg::SRC_TRIG_B) & trigB));

  // register file: one-wait-state read/write, writes land on the release edge
  always_comb begin
    ctrl_next  = ctrl_reg;
    inc0_next  = inc0_reg;
    inc1_next  = inc1_reg;
    len0_next  = len0_reg;
    len1_next  = len1_reg;
    cfg_next   = cfg_reg;
    rep_next   = rep_reg;
    start_next = start_reg;
    limLo_next = limLo_reg;
    limHi_next = limHi_reg;
    den_next   = den_reg;
    ack_next   = busReq & ~ack_reg;
    rdata_next = rdata_reg;
    ctrl_next[frg_pkg::CTRL_START] = 1'b0; // start is a self-clearing strobe
    if (wrNow) begin
      case (avsAddress)
        frg_pkg::OFF_CTRL:     ctrl_next  = {1'b0, avsWritedata[3:0]};
        frg_pkg::OFF_SEG0_INC: inc0_next  = avsWritedata[29:0];
        frg_pkg::OFF_SEG1_INC: inc1_next  = avsWritedata[29:0];
        frg_pkg::OFF_SEG0_LEN: len0_next  = avsWritedata[15:0];
        frg_pkg::OFF_SEG1_LEN: len1_next  = avsWritedata[15:0];
        frg_pkg::OFF_SEG_CFG:  cfg_next   = avsWritedata[17:0];
        frg_pkg::OFF_REPEAT:   rep_next   = avsWritedata[12:0];
        frg_pkg::OFF_START:    start_next = avsWritedata;
        frg_pkg::OFF_LIM_LO_L: limLo_next[31:0]  = avsWritedata;
        frg_pkg::OFF_LIM_LO_H: limLo_next[33:32] = avsWritedata[1:0];
        frg_pkg::OFF_LIM_HI_L: limHi_next[31:0]  = avsWritedata;
        frg_pkg::OFF_LIM_HI_H: limHi_next[33:32] = avsWritedata[1:0];
        frg_pkg::OFF_DEN:      den_next   = avsWritedata;
        default: ;             // unmapped writes are dropped
      endcase
    end
    // read data captured on the first request edge, stands at release
    if (avsRead & ~ack_reg) begin
      case (avsAddress)
        frg_pkg::OFF_CTRL:     rdata_next = {27'h0, ctrl_reg};
        frg_pkg::OFF_STATUS:   rdata_next = {26'h0, cal_reg, vcoCalBusy,
                                             state_reg == frg_pkg::ST_DONE, seg_reg,
                                             state_reg == frg_pkg::ST_RUN, manualOn};
        frg_pkg::OFF_SEG0_INC: rdata_next = {2'h0, inc0_reg};
        frg_pkg::OFF_SEG1_INC: rdata_next = {2'h0, inc1_reg};
        frg_pkg::OFF_SEG0_LEN: rdata_next = {16'h0, len0_reg};
        frg_pkg::OFF_SEG1_LEN: rdata_next = {16'h0, len1_reg};
        frg_pkg::OFF_SEG_CFG:  rdata_next = {14'h0, cfg_reg};
        frg_pkg::OFF_REPEAT:   rdata_next = {3'h0, repCnt_reg, 3'h0, rep_reg};
        frg_pkg::OFF_START:    rdata_next = start_reg;
        frg_pkg::OFF_LIM_LO_L: rdata_next = limLo_reg[31:0];
        frg_pkg::OFF_LIM_LO_H: rdata_next = {30'h0, limLo_reg[33:32]};
        frg_pkg::OFF_LIM_HI_L: rdata_next = limHi_reg[31:0];
        frg_pkg::OFF_LIM_HI_H: rdata_next = {30'h0, limHi_reg[33:32]};
        frg_pkg::OFF_NUM_L:    rdata_next = num_reg[31:0];
        frg_pkg::OFF_NUM_H:    rdata_next = {30'h0, num_reg[33:32]};
        frg_pkg::OFF_DEN:      rdata_next = den_reg;
        default:               rdata_next = 32'h0; // unmapped reads zero
      endcase
    end
  end

  // ramp engine: manual stepping and the two-segment automatic sequencer
  always_comb begin
    state_next  = state_reg;
    seg_next    = seg_reg;
    cnt_next    = cnt_reg;
    repCnt_next = repCnt_reg;
    half_next   = ~half_reg;
    num_next    = num_reg;
    origin_next = origin_reg;
    cal_next    = 1'b0;
    // any enabled mode runs on a fixed 2^24 scale, even idle or done; register value only while disabled
    denOut_next = en ? 32'h0100_0000 : den_reg;
    if (!en) begin
      state_next = frg_pkg::ST_IDLE;
      num_next   = {2'h0, start_reg};
    end else if (manualOn) begin
      state_next = frg_pkg::ST_IDLE;
      // a rising step clock during calibration is simply lost
      if (clkRise & ~vcoCalBusy) begin
        num_next = stepClamp(num_reg, dirLvl ? inc1_reg : inc0_reg, limLo_reg, limHi_reg);
        cal_next = recal;
      end
    end else begin
      case (state_reg)
        frg_pkg::ST_IDLE: begin
          num_next = {2'h0, start_reg};
        end
        frg_pkg::ST_RUN: begin
          if (advance) begin
            seg_next = curNext;
            cnt_next = 16'h0;
            cal_next = recal;
            if (curRst) begin
              num_next = {2'h0, origin_reg};
            end
          end else if (tick) begin
            num_next = stepClamp(num_reg, seg_reg ? inc1_reg : inc0_reg,
                                 limLo_reg, limHi_reg);
            if (cnt_reg != 16'hffff) begin
              cnt_next = cnt_reg + 16'h1;
            end
          end
          // zero repeat count means free-running
          if (repEvent) begin
            repCnt_next = repCnt_reg + 13'h1;
            if ((rep_reg != 13'h0) && (repCnt_reg + 13'h1 >= rep_reg)) begin
              state_next = frg_pkg::ST_DONE;
            end
          end
        end
        frg_pkg::ST_DONE: ;    // holds last numerator until restarted
        default: state_next = frg_pkg::ST_IDLE;
      endcase
    end
    // start strobe (re)launches from segment zero at the start value;
    // sits outside the mode branches since the old enable may still be low
    if (startPulse) begin
      state_next  = frg_pkg::ST_RUN;
      seg_next    = 1'b0;
      cnt_next    = 16'h0;
      repCnt_next = 13'h0;
      half_next   = 1'b0;
      num_next    = {2'h0, start_reg};
      origin_next = start_reg;
      cal_next    = 1'b1;
    end
  end

  // state registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg    <= 5'h0;
      inc0_reg    <= 30'h0;
      inc1_reg    <= 30'h0;
      len0_reg    <= 16'h0;
      len1_reg    <= 16'h0;
      cfg_reg     <= frg_pkg::RST_CFG[17:0];
      rep_reg     <= 13'h0;
      start_reg   <= 32'h0;
      limLo_reg   <= frg_pkg::RST_LIM_LO;
      limHi_reg   <= frg_pkg::RST_LIM_HI;
      den_reg     <= frg_pkg::RST_DEN;
      ack_reg     <= 1'b0;
      rdata_reg   <= 32'h0;
      state_reg   <= frg_pkg::ST_IDLE;
      seg_reg     <= 1'b0;
      cnt_reg     <= 16'h0;
      repCnt_reg  <= 13'h0;
      half_reg    <= 1'b0;
      num_reg     <= 34'h0;
      origin_reg  <= 32'h0;
      cal_reg     <= 1'b0;
      denOut_reg  <= frg_pkg::RST_DEN;
      clkPrev_reg <= 1'b0;
      dirPrev_reg <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      inc0_reg    <= inc0_next;
      inc1_reg    <= inc1_next;
      len0_reg    <= len0_next;
      len1_reg    <= len1_next;
      cfg_reg     <= cfg_next;
      rep_reg     <= rep_next;
      start_reg   <= start_next;
      limLo_reg   <= limLo_next;
      limHi_reg   <= limHi_next;
      den_reg     <= den_next;
      ack_reg     <= ack_next;
      rdata_reg   <= rdata_next;
      state_reg   <= state_next;
      seg_reg     <= seg_next;
      cnt_reg     <= cnt_next;
      repCnt_reg  <= repCnt_next;
      half_reg    <= half_next;
      num_reg     <= num_next;
      origin_reg  <= origin_next;
      cal_reg     <= cal_next;
      denOut_reg  <= denOut_next;
      clkPrev_reg <= clkLvl;
      dirPrev_reg <= dirLvl;
    end
  end

  // outputs
  assign avsWaitrequest  = busReq & ~ack_reg;
  assign avsReaddata     = rdata_reg;
  assign vcoCalRequest   = cal_reg;
  assign fracNumerator   = num_reg;
  assign fracDenominator = denOut_reg;
  assign rampActive      = (state_reg == frg_pkg::ST_RUN) | manualOn;
endmodule

//--- verif/frg_ramp_properties.sv
// frg_ramp_properties: port-level assertions for the ramp generator top
`timescale 1ns/1ps
module frg_ramp_properties (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // register bus handshake
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic        avsWaitrequest,
  // pins and calibration
  input wire logic        stepClockPin,
  input wire logic        vcoCalBusy,
  input wire logic        vcoCalRequest,
  // synthesizer outputs
  input wire logic [33:0] fracNumerator,
  input wire logic [31:0] fracDenominator,
  input wire logic        rampActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // every new request is held off for one cycle first
  AST_WAIT_FIRST: assert property ($rose(avsRead || avsWrite) |-> avsWaitrequest)
    else $error("new request not held off");
  // exactly one wait cycle, never more
  AST_ONE_WAIT: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("wait longer than one cycle");
  // no stall without a request
  AST_IDLE_WAIT: assert property (!(avsRead || avsWrite) |-> !avsWaitrequest)
    else $error("stall without request");
  // while ramping the denominator is the fixed power of two
  AST_DEN_RAMP: assert property (rampActive && $past(rampActive) |-> fracDenominator == 32'h0100_0000)
    else $error("ramp denominator wrong");
  // nothing moves the numerator while the vco calibrates
  AST_CAL_HOLD: assert property (vcoCalBusy |=> $stable(fracNumerator))
    else $error("numerator moved during calibration");
  // calibration request is a single-cycle pulse
  AST_CALREQ_PULSE: assert property (vcoCalRequest |=> !vcoCalRequest)
    else $error("calibration request too long");
  // idle ramp leaves the numerator alone; a write landing two edges back may reload it
  AST_IDLE_HOLD: assert property (!rampActive && !$past(rampActive)
    && !($past(avsWrite, 2) && !$past(avsWaitrequest, 2)) |-> $stable(fracNumerator))
    else $error("numerator moved while idle");
  // a pin edge must cross the synchroniser before it steps
  AST_SYNC_DELAY: assert property ($rose(stepClockPin) |=> $stable(fracNumerator) [*2])
    else $error("step applied before synchronisation");
endmodule

bind frg_ramp_top frg_ramp_properties u_props (.clk(clk), .resetn(resetn), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsWaitrequest(avsWaitrequest), .stepClockPin(stepClockPin),
  .vcoCalBusy(vcoCalBusy), .vcoCalRequest(vcoCalRequest), .fracNumerator(fracNumerator),
  .fracDenominator(fracDenominator), .rampActive(rampActive));

//--- verif/frg_step_ctrl.sv
// frg_step_ctrl: model of the external controller driving the step pins
`timescale 1ns/1ps
module frg_step_ctrl #(
  parameter int HALF_CYC = 250  // 500-cycle slot keeps steps at 250 kHz
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // step request from the bench
  input  wire logic stepReq,
  input  wire logic stepDir,
  input  wire logic dirOnly,
  // pins and status
  output logic      stepClockPin,
  output logic      stepDirectionPin,
  output logic      ctrlBusy
);
  int cnt;  // cycles into the current slot

  // direction settles first, clock rises well after it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      ctrlBusy <= 1'b0;
      stepClockPin <= 1'b0;
      stepDirectionPin <= 1'b0;
    end else if (!ctrlBusy) begin
      if (stepReq) begin
        ctrlBusy <= 1'b1;
        cnt <= 0;
        stepDirectionPin <= stepDir;
      end
    end else begin
      cnt <= cnt + 1;
      if (cnt == HALF_CYC / 5 && !dirOnly) stepClockPin <= 1'b1;
      if (cnt == HALF_CYC) stepClockPin <= 1'b0;
      if (cnt == 2 * HALF_CYC) ctrlBusy <= 1'b0;
    end
  end
endmodule

//--- verif/test_frequency_ramp_generator.sv
// test_frequency_ramp_generator: self-checking bench for the ramp generator
`timescale 1ns/1ps
module test_frequency_ramp_generator;
  // clock, reset and bus
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  avsAddress = 8'h00;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  // pins, calibration, outputs
  logic        stepClockPin;
  logic        stepDirectionPin;
  logic        vcoCalBusy = 1'b0;
  logic        vcoCalRequest;
  logic [33:0] fracNumerator;
  logic [31:0] fracDenominator;
  logic        rampActive;
  // partner control
  logic        stepReq = 1'b0;
  logic        stepDir = 1'b0;
  logic        dirOnly = 1'b0;
  logic        ctrlBusy;
  // scoring
  int          n_errors = 0;
  int          checks_done = 0;
  int          calPulses = 0;
  logic [31:0] rdData;
  localparam logic [33:0] START = 34'h64;        // ramp origin
  localparam logic [33:0] INC0  = 34'h2;
  localparam logic [33:0] INC1  = 34'h3_ffff_ffff; // minus one

  always #4 clk = ~clk;
  // count calibration pulses
  always @(posedge clk) if (vcoCalRequest === 1'b1) calPulses++;

  frg_ramp_top dut (.clk(clk), .resetn(resetn), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .stepClockPin(stepClockPin),
    .stepDirectionPin(stepDirectionPin), .vcoCalBusy(vcoCalBusy),
    .vcoCalRequest(vcoCalRequest), .fracNumerator(fracNumerator),
    .fracDenominator(fracDenominator), .rampActive(rampActive));
  frg_step_ctrl u_ctrl (.clk(clk), .resetn(resetn), .stepReq(stepReq), .stepDir(stepDir),
    .dirOnly(dirOnly), .stepClockPin(stepClockPin), .stepDirectionPin(stepDirectionPin),
    .ctrlBusy(ctrlBusy));

  task automatic test_done;
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one bus cycle, held until the wait is lifted
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (!avsWaitrequest) break;
    end
    rdData = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (k == 50) begin
      n_errors++;
      test_done;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // one controller slot; returns after the pins are back at rest
  task automatic step(input logic dir, input logic only);
    int k;
    @(posedge clk);
    stepReq <= 1'b1;
    stepDir <= dir;
    dirOnly <= only;
    @(posedge clk);
    stepReq <= 1'b0;
    @(posedge clk);
    for (k = 0; k < 2000 && ctrlBusy; k++) @(posedge clk);
    if (k == 2000) begin
      n_errors++;
      test_done;
    end
  endtask

  // wait for the numerator to show the origin after a start write
  task automatic syncStart;
    int k;
    @(posedge clk);
    for (k = 0; k < 10 && fracNumerator !== START; k++) @(posedge clk);
    if (k == 10) begin
      n_errors++;
      test_done;
    end
  endtask

  task automatic s_reset;
    check(34'(fracDenominator), 34'(frg_pkg::RST_DEN));
    check(34'(rampActive), 34'h0);
    bus(1'b0, frg_pkg::OFF_DEN, 32'h0);
    check(34'(rdData), 34'(frg_pkg::RST_DEN));
    bus(1'b0, 8'hfc, 32'h0);
    check(34'(rdData), 34'h0);
  endtask

  task automatic s_manual;
    wr(frg_pkg::OFF_SEG0_INC, 32'h5);
    wr(frg_pkg::OFF_SEG1_INC, 32'h3fff_fffd);
    wr(frg_pkg::OFF_CTRL, 32'hb);
    calPulses = 0;
    repeat (2) @(posedge clk);
    check(34'(fracDenominator), 34'h0100_0000);
    check(34'(rampActive), 34'h1);
    step(1'b0, 1'b0);
    check(fracNumerator, 34'h5);
    step(1'b1, 1'b0);
    check(fracNumerator, 34'h2);
    check(34'(calPulses), 34'h2);
    vcoCalBusy <= 1'b1;
    step(1'b0, 1'b0);
    vcoCalBusy <= 1'b0;
    check(fracNumerator, 34'h2);
    wr(frg_pkg::OFF_CTRL, 32'h0);
  endtask

  // cycle-exact model of a two-segment timeout ramp
  task automatic autoRun(input logic [31:0] cfg, input logic [31:0] rep, input logic [31:0] ctl);
    logic [33:0] exp;
    logic        seg;
    logic        done;
    int          cnt;
    int          nAdv;
    int          i;
    wr(frg_pkg::OFF_SEG_CFG, cfg);
    wr(frg_pkg::OFF_REPEAT, rep);
    calPulses = 0;
    wr(frg_pkg::OFF_CTRL, ctl);
    syncStart;
    exp = START;
    seg = 1'b0;
    done = 1'b0;
    cnt = 0;
    nAdv = 0;
    for (i = 0; i < 30; i++) begin
      @(posedge clk);
      if (!done && cnt == (seg ? 2 : 3)) begin
        if (seg ? cfg[7] : cfg[6]) exp = START;
        seg = seg ? cfg[1] : cfg[0];
        cnt = 0;
        nAdv++;
        if (nAdv == rep) done = 1'b1;
      end else if (!done) begin
        exp = exp + (seg ? INC1 : INC0);
        cnt++;
      end
      check(fracNumerator, exp);
    end
    @(negedge clk);
    if (ctl[3]) check(34'(calPulses), 34'(nAdv + 1));
    check(34'(rampActive), 34'(!done));
    wr(frg_pkg::OFF_CTRL, 32'h0);
  endtask

  // segment zero never advances; numerator checked after twenty cycles
  task automatic autoHold(input logic [31:0] ctl, input logic [33:0] expv);
    wr(frg_pkg::OFF_SEG_CFG, 32'hc);
    wr(frg_pkg::OFF_CTRL, ctl);
    syncStart;
    repeat (20) @(posedge clk);
    check(fracNumerator, expv);
    wr(frg_pkg::OFF_CTRL, 32'h0);
  endtask

  // direction rise on trigger B, direction fall on trigger A, then trigger A always
  task automatic s_trigger;
    logic [33:0] n1;
    logic [31:0] cfgs [3];
    int          i;
    cfgs = '{32'h0000_2039, 32'h0000_0a35, 32'h0000_0435};
    for (i = 0; i < 3; i++) begin
      wr(frg_pkg::OFF_SEG_CFG, cfgs[i]);
      wr(frg_pkg::OFF_CTRL, 32'h11);
      repeat (10) @(posedge clk);
      step(i == 0, 1'b1);
      n1 = fracNumerator;
      @(posedge clk);
      check(fracNumerator, n1 + INC1);
      wr(frg_pkg::OFF_CTRL, 32'h0);
    end
  endtask

  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    s_reset;
    s_manual;
    wr(frg_pkg::OFF_SEG0_INC, INC0[31:0]);
    wr(frg_pkg::OFF_SEG1_INC, 32'h3fff_ffff);
    wr(frg_pkg::OFF_SEG0_LEN, 32'h3);
    wr(frg_pkg::OFF_SEG1_LEN, 32'h2);
    wr(frg_pkg::OFF_START, START[31:0]);
    autoRun(32'h1, 32'h3, 32'h11);
    autoRun(32'hc1, 32'h0, 32'h19);
    autoHold(32'h15, START + 34'd20);
    wr(frg_pkg::OFF_LIM_HI_L, 32'h6b);
    wr(frg_pkg::OFF_LIM_HI_H, 32'h0);
    autoHold(32'h11, 34'h6b);
    wr(frg_pkg::OFF_LIM_HI_L, 32'hffff_ffff);
    wr(frg_pkg::OFF_LIM_HI_H, 32'h1);
    s_trigger;
    test_done;
  end

  // watchdog against a hang
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    test_done;
  end
endmodule
